// File: core/hpm_pkg.sv
/*
  package for the halt power mode control block: register map, field
  positions, reset values, state codes and timing counts.
  assumes a 10 mhz aclk and an axi4-lite master with 32-bit data.
*/
package hpm_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h10;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_OSC_IRQ = 0;   // osc_irq_enable
  localparam int CTRL_LONG = 1;      // restart delay option
  localparam int CTRL_WDSTOP = 2;    // watchdog_stop_option
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // ---------------------------------------------------------------
  // interrupt status fields
  // ---------------------------------------------------------------
  localparam int EV_ENTER_FULL = 0;
  localparam int EV_ENTER_TB = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_WDOG = 3;
  localparam int EV_W = 4;
  // ---------------------------------------------------------------
  // cpu side constants
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_HALT = 8'h8e;
  localparam logic [1:0] MASK_LEVEL_WAKE = 2'h2;
  localparam int NUM_XIRQ = 4;
  // ---------------------------------------------------------------
  // restart delay, in cpu cycles (one cpu cycle = one aclk)
  // ---------------------------------------------------------------
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC = 4096;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] DELAY_SHORT = CNT_W'(DELAY_SHORT_CYC);
  localparam logic [CNT_W-1:0] DELAY_LONG = CNT_W'(DELAY_LONG_CYC);
  // ---------------------------------------------------------------
  // power states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_FULL_STOP = 3'b001,
    ST_TB_STOP = 3'b010,
    ST_RESTART = 3'b011,
    ST_TB_GUARD = 3'b100
  } hpm_state_t;
  typedef enum logic [1:0] {
    RS_NONE = 2'b00,
    RS_IRQ = 2'b01,
    RS_RESET = 2'b10
  } hpm_resume_t;
endpackage

// File: core/hpm_sync.sv
/*
  two-flop synchroniser for a bundle of asynchronous levels.
  assumes the inputs may change at any time relative to aclk.
*/
`timescale 1ns/100ps
module hpm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } hpm_sync_st_t;
  hpm_sync_st_t st;
  hpm_sync_st_t next_st;

  // first flop feeds only the second
  always_comb
  begin
    next_st.meta = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_out = st.stable;
endmodule

// File: core/hpm_wake_latch.sv
/*
  clockless wake request latch: catches wake sources while the core
  clock is stopped and releases them once the clock side acknowledges.
  assumes ack comes from the aclk domain after the request is synced.
*/
`timescale 1ns/100ps
module hpm_wake_latch (
  // reset and release
  input wire logic aresetn,
  input wire logic ack,
  // asynchronous wake sources
  input wire logic wake_src,
  // latched request, asynchronous to aclk
  output logic wake_req
);
  // set by the source edge itself, no clock needed
  always_ff @(posedge wake_src or posedge ack or negedge aresetn)
  begin
    if (!aresetn)
      wake_req <= 1'b0;
    else if (ack)
      wake_req <= 1'b0;
    else
      wake_req <= 1'b1;
  end
endmodule

// File: core/hpm_ctrl.sv
/*
  halt power mode control: decodes the halt opcode, chooses the full stop
  or timebase-kept stop mode, gates clocks, times the oscillator restart
  and tells the cpu whether to service an interrupt or fetch the reset
  vector. registers over axi4-lite.
  assumes a 10 mhz aclk that keeps running in simulation; oscillator and
  clock gates are modelled by enables driven from here.
*/
`timescale 1ns/100ps
module hpm_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu instruction side
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic [1:0] cc_mask_in,
  input wire logic [1:0] irq_priority,
  // wake sources
  input wire logic [hpm_pkg::NUM_XIRQ-1:0] ext_irq,
  input wire logic [hpm_pkg::NUM_XIRQ-1:0] ext_irq_halt_capable,
  input wire logic timebase_irq,
  input wire logic reset_wake,
  input wire logic watchdog_active,
  // cpu control
  output logic cpu_stall,
  output logic cc_push,
  output logic [1:0] cc_mask_out,
  output logic cc_mask_force,
  output logic resume_irq,
  output logic fetch_reset_vector,
  // clock and reset gating
  output logic osc_enable,
  output logic timebase_clk_en,
  output logic periph_clk_en,
  output logic watchdog_reset,
  // interrupt
  output logic irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    hpm_pkg::hpm_state_t state;
    hpm_pkg::hpm_resume_t resume;
    logic [hpm_pkg::CNT_W-1:0] cnt;
    logic [2:0] ctrl;
    logic [hpm_pkg::NUM_XIRQ-1:0] wake_en;
    logic [hpm_pkg::EV_W-1:0] irq_status;
    logic [hpm_pkg::EV_W-1:0] irq_mask;
    logic wake_ack;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic cc_push;
    logic resume_irq;
    logic fetch_rv;
    logic wd_reset;
    logic [1:0] cc_mask;
    logic cc_force;
  } hpm_ctrl_st_t;
  hpm_ctrl_st_t st;
  hpm_ctrl_st_t next_st;

  logic [hpm_pkg::NUM_XIRQ-1:0] xirq_s;
  logic tb_s;
  logic rst_s;
  logic wake_async;
  logic wake_req;
  logic wake_s;
  logic halt_seen;
  logic irq_any;
  logic wr_go;
  logic rd_go;
  logic [hpm_pkg::EV_W-1:0] ev;
  logic [31:0] rd_val;
  logic [hpm_pkg::CNT_W-1:0] delay;

  // ---------------------------------------------------------------
  // synchronisers and clockless wake latch
  // ---------------------------------------------------------------
  hpm_sync #(.W(hpm_pkg::NUM_XIRQ + 2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({ext_irq, timebase_irq, reset_wake}),
    .sync_out({xirq_s, tb_s, rst_s})
  );

  // only halt-capable enabled lines or reset may raise it
  assign wake_async = |(ext_irq & ext_irq_halt_capable & st.wake_en) | reset_wake;

  hpm_wake_latch u_latch (
    .aresetn(aresetn),
    .ack(st.wake_ack),
    .wake_src(wake_async),
    .wake_req(wake_req)
  );

  hpm_sync #(.W(1)) u_wsync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(wake_req),
    .sync_out(wake_s)
  );

  // ---------------------------------------------------------------
  // decode and helpers
  // ---------------------------------------------------------------
  assign halt_seen = opcode_valid && (opcode == hpm_pkg::OPC_HALT);
  assign irq_any = |(xirq_s & st.wake_en);
  assign delay = st.ctrl[hpm_pkg::CTRL_LONG] ? hpm_pkg::DELAY_LONG
                                               : hpm_pkg::DELAY_SHORT;
  assign wr_go = st.aw_hold && st.w_hold && !st.bvalid;
  assign rd_go = s_axi_arvalid && !st.rvalid;

  // read mux
  always_comb
  begin
    rd_val = '0;
    case (s_axi_araddr)
      hpm_pkg::ADDR_CTRL: rd_val[2:0] = st.ctrl;
      hpm_pkg::ADDR_STATUS: rd_val[4:0] = {st.resume, st.state};
      hpm_pkg::ADDR_IRQ_STATUS: rd_val[hpm_pkg::EV_W-1:0] = st.irq_status;
      hpm_pkg::ADDR_IRQ_MASK: rd_val[hpm_pkg::EV_W-1:0] = st.irq_mask;
      hpm_pkg::ADDR_WAKE_EN: rd_val[hpm_pkg::NUM_XIRQ-1:0] = st.wake_en;
      default: rd_val = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    ev = '0;
    next_st.cc_push = 1'b0;
    next_st.resume_irq = 1'b0;
    next_st.fetch_rv = 1'b0;
    next_st.wd_reset = 1'b0;
    next_st.cc_force = 1'b0;
    // power sequencer
    case (st.state)
      hpm_pkg::ST_RUN:
      begin
        if (halt_seen)
        begin
          next_st.cc_force = 1'b1;
          next_st.cc_mask = hpm_pkg::MASK_LEVEL_WAKE;
          if (st.ctrl[hpm_pkg::CTRL_OSC_IRQ])
          begin
            next_st.state = hpm_pkg::ST_TB_STOP;
            ev[hpm_pkg::EV_ENTER_TB] = 1'b1;
          end
          else if (watchdog_active && !st.ctrl[hpm_pkg::CTRL_WDSTOP])
          begin
            next_st.wd_reset = 1'b1;
            ev[hpm_pkg::EV_WDOG] = 1'b1;
          end
          else
          begin
            next_st.state = hpm_pkg::ST_FULL_STOP;
            ev[hpm_pkg::EV_ENTER_FULL] = 1'b1;
          end
        end
      end
      hpm_pkg::ST_TB_STOP:
      begin
        if (rst_s)
        begin
          next_st.state = hpm_pkg::ST_RESTART;
          next_st.resume = hpm_pkg::RS_RESET;
          next_st.cnt = delay;
          ev[hpm_pkg::EV_WAKE] = 1'b1;
        end
        else if (irq_any || tb_s)
        begin
          // service at once, no restart wait
          next_st.state = tb_s ? hpm_pkg::ST_TB_GUARD : hpm_pkg::ST_RUN;
          next_st.cnt = delay;
          next_st.resume = hpm_pkg::RS_IRQ;
          next_st.resume_irq = 1'b1;
          next_st.cc_push = 1'b1;
          next_st.cc_force = 1'b1;
          next_st.cc_mask = irq_priority;
          ev[hpm_pkg::EV_WAKE] = 1'b1;
        end
      end
      hpm_pkg::ST_TB_GUARD:
      begin
        // running, but enable must hold for the rest of the delay
        next_st.cnt = st.cnt - hpm_pkg::CNT_W'(1);
        if (!st.ctrl[hpm_pkg::CTRL_OSC_IRQ])
        begin
          next_st.state = hpm_pkg::ST_RESTART;
          next_st.resume = hpm_pkg::RS_NONE;
          ev[hpm_pkg::EV_ENTER_FULL] = 1'b1;
        end
        else if (st.cnt <= hpm_pkg::CNT_W'(1))
          next_st.state = hpm_pkg::ST_RUN;
        else if (halt_seen)
          next_st.state = hpm_pkg::ST_RUN;
      end
      hpm_pkg::ST_FULL_STOP:
      begin
        if (wake_s)
        begin
          next_st.state = hpm_pkg::ST_RESTART;
          next_st.cnt = delay;
          next_st.resume = rst_s ? hpm_pkg::RS_RESET : hpm_pkg::RS_IRQ;
          ev[hpm_pkg::EV_WAKE] = 1'b1;
        end
      end
      hpm_pkg::ST_RESTART:
      begin
        next_st.cnt = st.cnt - hpm_pkg::CNT_W'(1);
        if (st.cnt <= hpm_pkg::CNT_W'(1))
        begin
          next_st.state = hpm_pkg::ST_RUN;
          next_st.fetch_rv = (st.resume == hpm_pkg::RS_RESET);
          next_st.resume_irq = (st.resume == hpm_pkg::RS_IRQ);
          next_st.cc_push = (st.resume == hpm_pkg::RS_IRQ);
          next_st.cc_force = (st.resume == hpm_pkg::RS_IRQ);
          next_st.cc_mask = irq_priority;
        end
      end
      default: next_st.state = hpm_pkg::ST_RUN;
    endcase
    // latch held clear outside full stop, so stale edges never wake it
    next_st.wake_ack = (next_st.state != hpm_pkg::ST_FULL_STOP);
    // axi write channel capture and register write
    if (s_axi_awvalid && !st.aw_hold)
    begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_hold)
    begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.w_strb[0])
      begin
        case (st.aw_addr)
          hpm_pkg::ADDR_CTRL: next_st.ctrl = st.w_data[2:0];
          hpm_pkg::ADDR_IRQ_MASK: next_st.irq_mask = st.w_data[hpm_pkg::EV_W-1:0];
          hpm_pkg::ADDR_WAKE_EN: next_st.wake_en = st.w_data[hpm_pkg::NUM_XIRQ-1:0];
          default: next_st.ctrl = next_st.ctrl;
        endcase
      end
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // axi read; status read clears, new events win
    if (rd_go)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      if (s_axi_araddr == hpm_pkg::ADDR_IRQ_STATUS)
        next_st.irq_status = '0;
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    next_st.irq_status = next_st.irq_status | ev;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.state <= hpm_pkg::ST_RUN;
      st.ctrl <= hpm_pkg::CTRL_RESET;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !st.aw_hold;
  assign s_axi_wready = !st.w_hold;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = 2'h0;
  // gating: full stop and restart keep peripherals off
  assign osc_enable = (st.state != hpm_pkg::ST_FULL_STOP);
  assign timebase_clk_en = (st.state != hpm_pkg::ST_FULL_STOP)
                           && (st.state != hpm_pkg::ST_RESTART);
  assign periph_clk_en = (st.state == hpm_pkg::ST_RUN)
                         || (st.state == hpm_pkg::ST_TB_GUARD);
  assign cpu_stall = !periph_clk_en;
  assign cc_push = st.cc_push;
  assign cc_mask_out = st.cc_mask;
  assign cc_mask_force = st.cc_force;
  assign resume_irq = st.resume_irq;
  assign fetch_reset_vector = st.fetch_rv;
  assign watchdog_reset = st.wd_reset;
  assign irq = |(st.irq_status & st.irq_mask);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_choice_a: assert property (st.state == hpm_pkg::ST_RUN && halt_seen
    && st.ctrl[hpm_pkg::CTRL_OSC_IRQ] |=> st.state == hpm_pkg::ST_TB_STOP)
    else $error("halt with enable set did not enter timebase stop");
  full_choice_a: assert property (st.state == hpm_pkg::ST_RUN && halt_seen
    && !st.ctrl[hpm_pkg::CTRL_OSC_IRQ] && !watchdog_active
    |=> st.state == hpm_pkg::ST_FULL_STOP)
    else $error("halt with enable clear did not enter full stop");
  mask_force_a: assert property ($rose(st.state == hpm_pkg::ST_TB_STOP)
    |-> cc_mask_force && cc_mask_out == hpm_pkg::MASK_LEVEL_WAKE)
    else $error("mask level not forced on stop entry");
  tb_fast_a: assert property (st.state == hpm_pkg::ST_TB_STOP && !rst_s
    && tb_s |=> resume_irq && !cpu_stall)
    else $error("timebase wake not serviced at once");
  no_delay_a: assert property ($past(st.state) == hpm_pkg::ST_TB_STOP
    && resume_irq |-> st.state != hpm_pkg::ST_RESTART)
    else $error("interrupt wake waited restart delay");
  osc_off_a: assert property (st.state == hpm_pkg::ST_FULL_STOP
    |-> !osc_enable && !periph_clk_en)
    else $error("oscillator on in full stop");
  tb_clock_a: assert property (st.state == hpm_pkg::ST_TB_STOP
    |-> osc_enable && timebase_clk_en && !periph_clk_en)
    else $error("wrong clock gating in timebase stop");
  no_wdog_a: assert property (halt_seen && st.state == hpm_pkg::ST_RUN
    && st.ctrl[hpm_pkg::CTRL_OSC_IRQ] |=> !watchdog_reset)
    else $error("watchdog reset from timebase stop entry");
  short_wait_a: assert property (st.state == hpm_pkg::ST_FULL_STOP && wake_s
    && !st.ctrl[hpm_pkg::CTRL_LONG] |=> (st.state == hpm_pkg::ST_RESTART)[*8])
    else $error("restart ended early");
  early_drop_a: assert property (st.state == hpm_pkg::ST_TB_GUARD
    && !st.ctrl[hpm_pkg::CTRL_OSC_IRQ] |=> !periph_clk_en)
    else $error("early enable clear did not stop");

  enter_tb_c: cover property (st.state == hpm_pkg::ST_TB_STOP);
  full_wake_c: cover property (st.state == hpm_pkg::ST_RESTART ##1 st.state == hpm_pkg::ST_RUN);
  wdog_c: cover property (watchdog_reset);
  guard_drop_c: cover property (st.state == hpm_pkg::ST_TB_GUARD ##1 st.state == hpm_pkg::ST_RESTART);
endmodule

// File: verification/hpm_cpu_model.sv
/*
  cpu core model facing the halt power mode block.
  assumes the bench asks for one instruction at a time through go.
*/
`timescale 1ns/100ps
module hpm_cpu_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench request
  input wire logic go,
  input wire logic [7:0] go_op,
  // core side of the block
  output logic [7:0] opcode,
  output logic opcode_valid,
  output logic [1:0] cc_mask_in,
  output logic [1:0] irq_priority,
  input wire logic cpu_stall,
  input wire logic cc_push,
  input wire logic [1:0] cc_mask_out,
  input wire logic cc_mask_force,
  // mask level as the core holds it
  output logic [1:0] cur_mask
);
  logic [1:0] saved_mask;
  // ---------------------------------------------------------------
  // instruction issue and condition code tracking
  // ---------------------------------------------------------------
  assign cc_mask_in = cur_mask;
  assign irq_priority = 2'h1; // level of the serviced routine
  // idle opcode toggles each cycle so a stale byte never lingers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opcode <= 8'h00;
      opcode_valid <= 1'b0;
      cur_mask <= 2'h3;
      saved_mask <= 2'h3;
    end
    else
    begin
      opcode_valid <= go && !cpu_stall;
      opcode <= (go && !cpu_stall) ? go_op : ~opcode;
      if (cc_push)
        saved_mask <= cur_mask; // stacked copy of the mask
      if (cc_mask_force)
        cur_mask <= cc_mask_out;
      else if (cc_push)
        cur_mask <= irq_priority;
    end
  end
endmodule

// File: verification/tb.sv
/*
  self-checking bench for the halt power mode block.
  assumes a 10 mhz aclk and the cpu model on the instruction side.
*/
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] A_CTRL = hpm_pkg::ADDR_CTRL;
  localparam logic [7:0] A_IRQ = hpm_pkg::ADDR_IRQ_STATUS;
  localparam int DS = hpm_pkg::DELAY_SHORT_CYC;
  localparam int DL = hpm_pkg::DELAY_LONG_CYC;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, cc_mask_in, irq_priority, cc_mask_out, cur_mask;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0] opcode, go_op = 8'h00;
  logic [3:0] ext_irq = 4'h0, ext_irq_halt_capable = 4'h1;
  logic timebase_irq = 1'b0, reset_wake = 1'b0, watchdog_active = 1'b0, go = 1'b0;
  logic opcode_valid, cpu_stall, cc_push, cc_mask_force, resume_irq, fetch_reset_vector;
  logic osc_enable, timebase_clk_en, periph_clk_en, watchdog_reset, irq;
  int err_total = 0, checks_done = 0, cyc = 0;
  // ---------------------------------------------------------------
  // clock, instances and run limit
  // ---------------------------------------------------------------
  always #50 aclk = ~aclk;
  hpm_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .opcode, .opcode_valid, .cc_mask_in, .irq_priority, .ext_irq,
    .ext_irq_halt_capable, .timebase_irq, .reset_wake, .watchdog_active, .cpu_stall, .cc_push,
    .cc_mask_out, .cc_mask_force, .resume_irq, .fetch_reset_vector, .osc_enable,
    .timebase_clk_en, .periph_clk_en, .watchdog_reset, .irq);
  hpm_cpu_model cpu (.aclk, .aresetn, .go, .go_op, .opcode, .opcode_valid, .cc_mask_in,
    .irq_priority, .cpu_stall, .cc_push, .cc_mask_out, .cc_mask_force, .cur_mask);
  // cut a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      $display("[FAIL] run length expected below %0d seen %0d", 30000, cyc);
      stop_test();
    end
  end
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ---------------------------------------------------------------
  // bus and core helpers
  // ---------------------------------------------------------------
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk("write answer", 1, s_axi_bvalid);
    chk("write resp", 0, {30'h0, s_axi_bresp});
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    chk("read resp", 0, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask
  // issue one instruction, then look for a watchdog pulse and the stall
  task halt(input logic [7:0] op, input logic wd, input logic st);
    logic w;
    w = 1'b0;
    @(posedge aclk);
    go_op <= op;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (4)
    begin
      @(negedge aclk);
      w = w | watchdog_reset;
    end
    chk("watchdog reset", {31'h0, wd}, {31'h0, w});
    chk("stall", {31'h0, st}, {31'h0, cpu_stall});
  endtask
  // src 0/1 external line, 2 timebase, 3 reset request
  task wake(input int src, input int lo, input int hi);
    int n;
    logic o;
    n = 0;
    o = 1'b0;
    @(posedge aclk);
    ext_irq <= (src < 2) ? 4'(1 << src) : 4'h0;
    timebase_irq <= (src == 2);
    reset_wake <= (src == 3);
    do
    begin
      @(negedge aclk);
      n++;
      if (n == 16) o = osc_enable;
    end while (resume_irq !== 1'b1 && fetch_reset_vector !== 1'b1 && n < 6000);
    chk("wake latency in range", 1, n >= lo && n <= hi);
    chk("resume kind", src == 3, {31'h0, fetch_reset_vector});
    if (lo > 100) chk("osc restarted", 1, {31'h0, o});
    @(posedge aclk);
    ext_irq <= 4'h0;
    timebase_irq <= 1'b0;
    reset_wake <= 1'b0;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while (cpu_stall !== 1'b0 && n < 6000);
    chk("back in run", 0, {31'h0, cpu_stall});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    axi_rd(A_CTRL, rd);
    chk("ctrl reset", 0, rd);
    axi_rd(hpm_pkg::ADDR_STATUS, rd);
    chk("status reset", 0, rd);
    axi_rd(8'h14, rd);
    chk("unmapped read", 0, rd);
    chk("clocks on", 3, {30'h0, osc_enable, periph_clk_en});
    axi_wr(hpm_pkg::ADDR_WAKE_EN, 32'h3);
    axi_rd(A_IRQ, rd);
  endtask
  task t_tb;
    axi_wr(A_CTRL, 32'h1);
    halt(hpm_pkg::OPC_HALT, 1'b0, 1'b1);
    chk("tb clocks", 6, {29'h0, osc_enable, timebase_clk_en, periph_clk_en});
    chk("mask forced", 2, {30'h0, cur_mask});
    wake(1, 1, 8);
    chk("mask priority", 1, {30'h0, cur_mask});
    chk("mask stacked", 2, {30'h0, cpu.saved_mask});
    halt(hpm_pkg::OPC_HALT, 1'b0, 1'b1);
    wake(3, DS, DS + 10);
  endtask
  task t_irq;
    chk("irq masked", 0, {31'h0, irq});
    axi_wr(hpm_pkg::ADDR_IRQ_MASK, 32'h6);
    chk("irq raised", 1, {31'h0, irq});
    axi_rd(A_IRQ, rd);
    chk("irq status", 32'h6, rd);
    chk("irq cleared", 0, {31'h0, irq});
    axi_wr(hpm_pkg::ADDR_IRQ_MASK, 32'h0);
  endtask
  task t_full(input logic lng);
    axi_wr(A_CTRL, {30'h0, lng, 1'b0});
    halt(8'h8f, 1'b0, 1'b0);
    halt(hpm_pkg::OPC_HALT, 1'b0, 1'b1);
    chk("full stop clocks", 0, {30'h0, osc_enable, periph_clk_en});
    chk("mask forced", 2, {30'h0, cur_mask});
    @(posedge aclk);
    ext_irq <= 4'h2;
    repeat (20) @(negedge aclk);
    chk("line without stop wake", 1, {31'h0, cpu_stall});
    wake(0, lng ? DL : DS, lng ? DL + 10 : DS + 10);
    chk("mask priority", 1, {30'h0, cur_mask});
  endtask
  task t_guard;
    int n;
    n = 0;
    axi_wr(A_CTRL, 32'h1);
    halt(hpm_pkg::OPC_HALT, 1'b0, 1'b1);
    @(posedge aclk);
    timebase_irq <= 1'b1;
    do
    begin
      @(negedge aclk);
      n++;
    end while (resume_irq !== 1'b1 && n < 20);
    chk("timebase wake fast", 1, n <= 8);
    @(posedge aclk);
    timebase_irq <= 1'b0;
    axi_wr(A_CTRL, 32'h0);
    repeat (2) @(negedge aclk);
    chk("early clear stalls", 1, {31'h0, cpu_stall});
    n = 0;
    while (cpu_stall !== 1'b0 && n < 400)
    begin
      @(negedge aclk);
      n++;
    end
    chk("rest of delay", 1, n > DS - 56 && n <= DS);
  endtask
  task t_wdog;
    @(posedge aclk);
    watchdog_active <= 1'b1;
    axi_wr(A_CTRL, 32'h0);
    halt(hpm_pkg::OPC_HALT, 1'b1, 1'b0);
    axi_wr(A_CTRL, 32'h1);
    halt(hpm_pkg::OPC_HALT, 1'b0, 1'b1);
    wake(2, 1, 8);
    repeat (DS + 8) @(negedge aclk);
    axi_wr(A_CTRL, 32'h4);
    halt(hpm_pkg::OPC_HALT, 1'b0, 1'b1);
    wake(0, DS, DS + 10);
    @(posedge aclk);
    watchdog_active <= 1'b0;
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    $display("reset and registers done");
    t_tb();
    $display("timebase stop done");
    t_irq();
    $display("interrupt done");
    t_full(1'b0);
    t_full(1'b1);
    $display("full stop done");
    t_guard();
    $display("early clear done");
    t_wdog();
    $display("watchdog done");
    stop_test();
  end
endmodule
